/* File: hdl/ssrw_pkg.sv */
// Purpose: Shared constants and types of the supply supervisor
// Assumes: 100 MHz system clock, 1 ms timing tick
// Notes: Offsets are byte addresses on the register bus
package ssrw_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TICK_MS = 1;
  localparam int CNT_W = 11;
  localparam logic [CNT_W-1:0] HOLD_MS_0 = 11'd50;
  localparam logic [CNT_W-1:0] HOLD_MS_1 = 11'd200;
  localparam logic [CNT_W-1:0] HOLD_MS_2 = 11'd400;
  localparam logic [CNT_W-1:0] HOLD_MS_3 = 11'd800;
  localparam logic [CNT_W-1:0] WD_MS_0 = 11'd25;
  localparam logic [CNT_W-1:0] WD_MS_1 = 11'd200;
  localparam logic [CNT_W-1:0] WD_MS_2 = 11'd1400;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;
  localparam int DEBOUNCE_MS = 10;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
  localparam int CTRL_HOLD_LSB = 0;
  localparam int CTRL_WD_LSB = 2;
  localparam logic [1:0] HOLD_SEL_RST = 2'h0;
  localparam logic [1:0] WD_SEL_RST = 2'h3;
  localparam int IRQ_MANUAL = 0;
  localparam int IRQ_LOWSUP = 1;
  localparam int IRQ_WDOG = 2;
  localparam int IRQ_SECOND = 3;
  localparam int IRQ_BACKUP = 4;
  localparam int IRQ_W = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 5'h00;

  typedef enum logic [2:0] {
    ST_CAUSE = 3'b001,
    ST_HOLD = 3'b010,
    ST_RUN = 3'b100
  } ssrw_rst_e;

  typedef struct packed {
    logic lowSupply;
    logic secondFail;
    logic mainBelowBatt;
  } ssrw_supply_s;

  typedef struct packed {
    logic valid;
    logic [7:0] addr;
  } ssrw_wreq_s;

  function automatic logic [CNT_W-1:0] holdTicks(input logic [1:0] sel);
    unique case (sel)
      2'h0: holdTicks = CNT_W'(HOLD_MS_0 / TICK_MS);
      2'h1: holdTicks = CNT_W'(HOLD_MS_1 / TICK_MS);
      2'h2: holdTicks = CNT_W'(HOLD_MS_2 / TICK_MS);
      2'h3: holdTicks = CNT_W'(HOLD_MS_3 / TICK_MS);
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] wdTicks(input logic [1:0] sel);
    unique case (sel)
      2'h0: wdTicks = CNT_W'(WD_MS_0 / TICK_MS);
      2'h1: wdTicks = CNT_W'(WD_MS_1 / TICK_MS);
      2'h2: wdTicks = CNT_W'(WD_MS_2 / TICK_MS);
      2'h3: wdTicks = '1;
    endcase
  endfunction
endpackage

/* File: hdl/ssrw_sync3.sv */
// Purpose: Three-stage synchroniser for asynchronous pins
// Assumes: Inputs arrive from outside the clock domain
// Notes: Output follows once stages two and three agree
`timescale 1ns/1ps
module ssrw_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      syncOut <= RST_VAL;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      syncOut <= (syncOut & ~agree) | (stage3 & agree);
    end
  end
endmodule // ssrw_sync3

/* File: hdl/ssrw_debounce.sv */
// Purpose: Debounce a synchronised level on the timing tick
// Assumes: levelIn already synchronised, tick is a one-cycle pulse
// Notes: Any bounce restarts the stability count
`timescale 1ns/1ps
module ssrw_debounce #(
  parameter int STABLE_TICKS = 10,
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic tick,
  input wire logic levelIn,
  output logic levelOut
);
  localparam int CW = $clog2(STABLE_TICKS + 1);
  logic [CW-1:0] stableCnt;
  logic differs;
  logic done;

  if (STABLE_TICKS < 1) begin : g_bad
    $error("STABLE_TICKS must be at least one");
  end

  assign differs = levelIn != levelOut;
  assign done = stableCnt == CW'(STABLE_TICKS - 1);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stableCnt <= '0;
      levelOut <= RST_VAL;
    end else if (!differs) begin
      stableCnt <= '0;
    end else if (tick) begin
      if (done) begin
        levelOut <= levelIn;
        stableCnt <= '0;
      end else begin
        stableCnt <= stableCnt + 1'b1;
      end
    end
  end
endmodule // ssrw_debounce

/* File: hdl/ssrw_top.sv */
// Purpose: Supply supervisor with reset hold, watchdog and battery switch
// Assumes: Comparator results arrive as logic levels on pins
// Notes: Registers reached over AHB-Lite, zero wait states
// How it works
// - Reset hold selectable: 50, 200, 400, 800 ms
// - Watchdog 25 ms, 200 ms, 1.4 s, off
// - Missing restart within interval raises watchdog fault
// - Watchdog interval kept in nonvolatile storage
// - Watchdog fault active low, open drain
// - Manual reset holds reset, then hold time
// - Manual reset input debounced internally
// - Low supply holds reset, then hold time
// - Power-up keeps reset for hold time
// - Reset polarity chosen by variant, open drain
// - Early low-supply output low while supply low
// - Second-supply fail follows comparator, no delay
// - Battery selected only when main low, below battery
// - Serial data fall then stop restarts watchdog
// - Backup-active output high while on battery
// - Write protect high rejects every write
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ssrw_top
  import ssrw_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int DEB_TICKS = DEBOUNCE_MS / TICK_MS,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic manualResetIn,
  input wire logic lowSupplyIn,
  input wire logic secondSupplySense,
  input wire logic mainBelowBatteryIn,
  input wire logic writeProtectIn,
  input wire logic serialClockIn,
  input wire logic serialDataIn,
  input wire logic [1:0] nvWdSel,
  output logic nvWdSelWrite,
  output logic [1:0] nvWdSelData,
  output logic systemResetO,
  output logic systemResetOe,
  output logic watchdogFaultNO,
  output logic watchdogFaultNOe,
  output logic earlyLowSupplyNO,
  output logic earlyLowSupplyNOe,
  output logic secondSupplyFailNO,
  output logic secondSupplyFailNOe,
  output logic backupActive,
  output logic irq
);
  localparam int DIV_W = $clog2(TICK_DIV);

  if (TICK_DIV < 2) begin : g_bad_div
    $error("TICK_DIV must be at least two");
  end

  // Synchronised pins
  ssrw_supply_s supply;
  logic [2:0] supplyRaw;
  logic [3:0] pinSync;
  logic manualSync;
  logic wpSync;
  logic sclSync;
  logic sdaSync;

  assign supplyRaw = {lowSupplyIn, ~secondSupplySense, mainBelowBatteryIn};

  ssrw_sync3 #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_supply_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinIn(supplyRaw),
    .syncOut(supply)
  );

  ssrw_sync3 #(
    .WIDTH(4),
    .RST_VAL(4'hb)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .pinIn({manualResetIn, writeProtectIn, serialClockIn, serialDataIn}),
    .syncOut(pinSync)
  );

  assign manualSync = pinSync[3];
  assign wpSync = pinSync[2];
  assign sclSync = pinSync[1];
  assign sdaSync = pinSync[0];

  // Internal timing tick
  logic [DIV_W-1:0] divCnt;
  logic tick;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divCnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= divCnt == DIV_W'(TICK_DIV - 1);
      divCnt <= (divCnt == DIV_W'(TICK_DIV - 1)) ? '0 : divCnt + 1'b1;
    end
  end

  // Manual reset debounce
  logic manualLevel;
  logic manualPressed;

  ssrw_debounce #(
    .STABLE_TICKS(DEB_TICKS),
    .RST_VAL(1'b1)
  ) u_manual_deb (
    .clk_sys(clk_sys),
    .reset(reset),
    .tick(tick),
    .levelIn(manualSync),
    .levelOut(manualLevel)
  );

  assign manualPressed = ~manualLevel;

  // Configuration registers
  logic [1:0] holdSel;
  logic [1:0] wdSel;
  logic nvLoadPending;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;

  // Reset sequencer
  ssrw_rst_e rstState;
  ssrw_rst_e next_rstState;
  logic [CNT_W-1:0] holdCnt;
  logic resetCause;
  logic holdDone;
  logic inReset;

  assign resetCause = supply.lowSupply | manualPressed;
  assign holdDone = tick && (holdCnt >= holdTicks(holdSel) - 1'b1);
  assign inReset = rstState != ST_RUN;

  always_comb begin
    next_rstState = rstState;
    unique case (rstState)
      ST_CAUSE: begin
        if (!resetCause) begin
          next_rstState = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (resetCause) begin
          next_rstState = ST_CAUSE;
        end else if (holdDone) begin
          next_rstState = ST_RUN;
        end
      end
      ST_RUN: begin
        if (resetCause) begin
          next_rstState = ST_CAUSE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rstState <= ST_CAUSE;
      holdCnt <= '0;
    end else begin
      rstState <= next_rstState;
      if (rstState != ST_HOLD) begin
        holdCnt <= '0;
      end else if (tick) begin
        holdCnt <= holdCnt + 1'b1;
      end
    end
  end

  // Watchdog restart from serial pins
  logic sclPrev;
  logic sdaPrev;
  logic restartArmed;
  logic sdaFall;
  logic stopSeen;
  logic wdRestart;

  assign sdaFall = sdaPrev && !sdaSync && sclPrev;
  assign stopSeen = !sdaPrev && sdaSync && sclSync;
  assign wdRestart = restartArmed && stopSeen;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
      restartArmed <= 1'b0;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
      if (stopSeen) begin
        restartArmed <= 1'b0;
      end else if (sdaFall) begin
        restartArmed <= 1'b1;
      end
    end
  end

  // Watchdog counter
  logic [CNT_W-1:0] wdCnt;
  logic wdFault;
  logic wdOff;
  logic wdHit;
  logic wdExpire;

  assign wdOff = wdSel == WD_SEL_OFF;
  assign wdHit = wdCnt >= wdTicks(wdSel) - 1'b1;
  assign wdExpire = tick && wdHit && !wdFault && !wdOff && !inReset && !wdRestart;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wdCnt <= '0;
      wdFault <= 1'b0;
    end else if (inReset || wdOff || nvLoadPending) begin
      wdCnt <= '0;
      wdFault <= 1'b0;
    end else if (wdRestart) begin
      wdCnt <= '0;
      wdFault <= 1'b0;
    end else if (wdExpire) begin
      wdFault <= 1'b1;
    end else if (tick && !wdFault) begin
      wdCnt <= wdCnt + 1'b1;
    end
  end

  // Battery switch decision
  logic onBattery;

  assign onBattery = supply.lowSupply & supply.mainBelowBatt;

  // AHB-Lite slave
  ssrw_wreq_s wreq;
  logic addrPhase;
  logic [7:0] apAddr;
  logic [31:0] rdWord;
  logic [31:0] statusWord;
  logic wrOk;
  logic wrCtrl;
  logic wrIrqStat;
  logic wrIrqMask;

  assign addrPhase = hsel && htrans[1] && hready;
  assign apAddr = {haddr[7:2], 2'b00};
  assign statusWord = {25'h0, wpSync, manualPressed, onBattery, supply.secondFail,
                       supply.lowSupply, wdFault, inReset};
  assign rdWord = (apAddr == OFS_CTRL) ?
                    {28'h0, wdSel, holdSel} :
                  (apAddr == OFS_STATUS) ? statusWord :
                  (apAddr == OFS_IRQ_STAT) ? {27'h0, irqStat} :
                  (apAddr == OFS_IRQ_MASK) ? {27'h0, irqMask} : 32'h0;
  assign wrOk = wreq.valid && !wpSync;
  assign wrCtrl = wrOk && (wreq.addr == OFS_CTRL);
  assign wrIrqStat = wrOk && (wreq.addr == OFS_IRQ_STAT);
  assign wrIrqMask = wrOk && (wreq.addr == OFS_IRQ_MASK);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wreq <= '0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wreq.valid <= addrPhase && hwrite;
      wreq.addr <= apAddr;
      if (addrPhase && !hwrite) begin
        hrdata <= rdWord;
      end
    end
  end

  // Events and interrupt
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] evPrev;
  logic [IRQ_W-1:0] evLevel;

  assign evLevel = {onBattery, supply.secondFail, wdFault, supply.lowSupply, manualPressed};
  assign events = {evLevel[IRQ_BACKUP:IRQ_SECOND] & ~evPrev[IRQ_BACKUP:IRQ_SECOND],
                   wdExpire,
                   evLevel[IRQ_LOWSUP:IRQ_MANUAL] & ~evPrev[IRQ_LOWSUP:IRQ_MANUAL]};

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evPrev <= IRQ_W'(1) << IRQ_LOWSUP;
      irqStat <= '0;
      irqMask <= IRQ_MASK_RST;
      irq <= 1'b0;
    end else begin
      evPrev <= evLevel;
      irqStat <= (irqStat & ~(wrIrqStat ? hwdata[IRQ_W-1:0] : '0)) | events;
      if (wrIrqMask) begin
        irqMask <= hwdata[IRQ_W-1:0];
      end
      irq <= |(irqStat & irqMask);
    end
  end

  // Control register and nonvolatile interval
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      holdSel <= HOLD_SEL_RST;
      wdSel <= WD_SEL_RST;
      nvLoadPending <= 1'b1;
      nvWdSelWrite <= 1'b0;
      nvWdSelData <= WD_SEL_RST;
    end else begin
      nvWdSelWrite <= 1'b0;
      if (nvLoadPending) begin
        wdSel <= nvWdSel;
        nvWdSelData <= nvWdSel;
        nvLoadPending <= 1'b0;
      end else if (wrCtrl) begin
        holdSel <= hwdata[CTRL_HOLD_LSB +: 2];
        wdSel <= hwdata[CTRL_WD_LSB +: 2];
        nvWdSelWrite <= 1'b1;
        nvWdSelData <= hwdata[CTRL_WD_LSB +: 2];
      end
    end
  end

  // Pin drivers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      systemResetO <= 1'b0;
      systemResetOe <= ~RESET_ACTIVE_HIGH;
      watchdogFaultNO <= 1'b0;
      watchdogFaultNOe <= 1'b0;
      earlyLowSupplyNO <= 1'b0;
      earlyLowSupplyNOe <= 1'b0;
      secondSupplyFailNO <= 1'b0;
      secondSupplyFailNOe <= 1'b0;
      backupActive <= 1'b0;
    end else begin
      systemResetOe <= RESET_ACTIVE_HIGH ? !inReset : inReset;
      watchdogFaultNOe <= wdFault;
      earlyLowSupplyNOe <= supply.lowSupply;
      secondSupplyFailNOe <= supply.secondFail;
      backupActive <= onBattery;
    end
  end
endmodule // ssrw_top

/* File: bench/ssrw_top_props.sv */
// Purpose: Port checks of the supply supervisor
// Assumes: Either reset variant, reset input active high
// Notes: Bound to every ssrw_top
`timescale 1ns/1ps
module ssrw_top_props #(
  parameter int TICK_DIV = 10,
  parameter int DEB_TICKS = 2,
  parameter bit RESET_ACTIVE_HIGH = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic manualResetIn,
  input wire logic lowSupplyIn,
  input wire logic secondSupplySense,
  input wire logic mainBelowBatteryIn,
  input wire logic systemResetO,
  input wire logic systemResetOe,
  input wire logic watchdogFaultNO,
  input wire logic watchdogFaultNOe,
  input wire logic earlyLowSupplyNO,
  input wire logic earlyLowSupplyNOe,
  input wire logic secondSupplyFailNO,
  input wire logic secondSupplyFailNOe,
  input wire logic backupActive
);
  int rstCnt;
  int runCnt;
  int manCnt;
  logic rstOn;
  // Reset asserted, whichever variant
  assign rstOn = systemResetOe ^ RESET_ACTIVE_HIGH;
  // Lengths of reset, run and manual press
  always_ff @(posedge clk_sys) begin
    rstCnt <= (reset || !rstOn) ? 0 : rstCnt + 1;
    runCnt <= (reset || rstOn) ? 0 : runCnt + 1;
    manCnt <= (reset || manualResetIn) ? 0 : manCnt + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_OPEN_DRAIN: assert property (!(systemResetO | watchdogFaultNO))
    else $error("open-drain pin driven high");
  AST_RST_MIN: assert property ($fell(rstOn) |-> rstCnt >= 49 * TICK_DIV)
    else $error("reset released before hold time");
  AST_WD_MIN: assert property ($rose(watchdogFaultNOe) |-> runCnt >= 24 * TICK_DIV)
    else $error("watchdog fault too early");
  AST_MAN: assert property (manCnt == (DEB_TICKS + 2) * TICK_DIV + 8 |-> rstOn)
    else $error("manual press gave no reset");
  AST_WD_IN_RST: assert property (rstOn [*3] |-> !watchdogFaultNOe)
    else $error("watchdog fault during reset");
  AST_LOW_RST: assert property (lowSupplyIn [*8] |-> ##[0:4] rstOn)
    else $error("low supply gave no reset");
  AST_EARLY: assert property ($stable(lowSupplyIn) [*8] |->
    earlyLowSupplyNOe == lowSupplyIn && !earlyLowSupplyNO)
    else $error("early low-supply pin wrong");
  AST_SECOND: assert property ($stable(secondSupplySense) [*8] |->
    secondSupplyFailNOe == !secondSupplySense && !secondSupplyFailNO)
    else $error("second-supply pin wrong");
  AST_BACKUP: assert property ($stable(lowSupplyIn & mainBelowBatteryIn) [*8] |->
    backupActive == (lowSupplyIn & mainBelowBatteryIn))
    else $error("supply selection wrong");
  cover property ($rose(watchdogFaultNOe));
  cover property ($fell(rstOn));
  cover property ($rose(backupActive));
endmodule // ssrw_top_props

bind ssrw_top ssrw_top_props #(.TICK_DIV(TICK_DIV), .DEB_TICKS(DEB_TICKS),
  .RESET_ACTIVE_HIGH(RESET_ACTIVE_HIGH)) u_props (
  .clk_sys, .reset, .manualResetIn, .lowSupplyIn, .secondSupplySense, .mainBelowBatteryIn,
  .systemResetO, .systemResetOe, .watchdogFaultNO, .watchdogFaultNOe, .earlyLowSupplyNO,
  .earlyLowSupplyNOe, .secondSupplyFailNO, .secondSupplyFailNOe, .backupActive);

/* File: bench/ssrw_host_model.sv */
// Purpose: Host processor restarting the watchdog on the two pins
// Assumes: Pins idle high by pull-ups
// Notes: Pace sets cycles per pin step
`timescale 1ns/1ps
module ssrw_host_model (
  input wire logic clk_sys,
  input wire logic inReset,
  input wire logic kick,
  input wire logic [3:0] pace,
  output logic scl,
  output logic sda,
  output logic busy
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    busy = 1'b0;
  end
  task automatic step(input logic c, input logic d);
    repeat (int'(pace) + 6) @(posedge clk_sys);
    scl <= c;
    sda <= d;
  endtask
  // Fall with clock high, clock low, clock high, stop
  always @(posedge clk_sys) begin
    if (kick && !inReset) begin
      busy <= 1'b1;
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      busy <= 1'b0;
    end
  end
endmodule // ssrw_host_model

/* File: bench/test_supply_supervisor_reset_watchdog.sv */
// Purpose: Self-checking bench of the supply supervisor
// Assumes: Short tick and debounce parameters
// Notes: NV cell modelled here
`timescale 1ns/1ps
module test_supply_supervisor_reset_watchdog
  import ssrw_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0, hwrite = 1'b0, kick = 1'b0, writeProtectIn = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, r;
  logic [1:0] htrans = 2'h0, nvWdSelData, nvStore = 2'h0;
  logic manualResetIn = 1'b1, lowSupplyIn = 1'b0, secondSupplySense = 1'b1;
  logic mainBelowBatteryIn = 1'b0, hreadyout, hresp, scl, sda, busy, nvWdSelWrite, irq;
  logic rstOe, wdOe, lowOe, secOe, backupActive, rstOeHi;
  logic [3:0] pace = 4'h0;
  logic [6:0] rows [7] = '{7'h20, 7'h04, 7'h30, 7'h4d, 7'h7b, 7'h5f, 7'h21};
  int wdExp [4] = '{250, 2000, 14000, 0};
  int holdExp [4] = '{500, 2000, 4000, 8000};
  int mismatches = 0, checks = 0, n;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (nvWdSelWrite) nvStore <= nvWdSelData;
  ssrw_top #(.TICK_DIV(10), .DEB_TICKS(2)) i_dut (
    .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .manualResetIn, .lowSupplyIn,
    .secondSupplySense, .mainBelowBatteryIn, .writeProtectIn, .serialClockIn(scl),
    .serialDataIn(sda), .nvWdSel(nvStore), .nvWdSelWrite, .nvWdSelData,
    .systemResetO(), .systemResetOe(rstOe), .watchdogFaultNO(), .watchdogFaultNOe(wdOe),
    .earlyLowSupplyNO(), .earlyLowSupplyNOe(lowOe), .secondSupplyFailNO(),
    .secondSupplyFailNOe(secOe), .backupActive, .irq);
  // Active-high reset variant on the same stimulus
  ssrw_top #(.TICK_DIV(10), .DEB_TICKS(2), .RESET_ACTIVE_HIGH(1'b1)) i_dut_hi (
    .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(), .manualResetIn, .lowSupplyIn,
    .secondSupplySense, .mainBelowBatteryIn, .writeProtectIn, .serialClockIn(scl),
    .serialDataIn(sda), .nvWdSel(nvStore), .nvWdSelWrite(), .nvWdSelData(),
    .systemResetO(), .systemResetOe(rstOeHi), .watchdogFaultNO(), .watchdogFaultNOe(),
    .earlyLowSupplyNO(), .earlyLowSupplyNOe(), .secondSupplyFailNO(),
    .secondSupplyFailNOe(), .backupActive(), .irq());
  ssrw_host_model i_host (.clk_sys, .inReset(rstOe), .kick, .pace, .scl, .sda, .busy);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic chkIn(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic waitOn(input bit wd, input logic lvl, input int lim);
    n = 0;
    while ((wd ? wdOe : rstOe) !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic doKick(input logic [3:0] p);
    @(posedge clk_sys);
    pace <= p;
    kick <= 1'b1;
    @(posedge clk_sys);
    kick <= 1'b0;
    do @(posedge clk_sys); while (busy);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    chk({27'h0, rstOeHi, wdOe, lowOe, secOe, rstOe}, 32'h1);
    reset <= 1'b0;
    waitOn(0, 1'b0, 1000);
    chkIn(n, 490, 530);
    ahb(0, OFS_CTRL, 0);
    chk(r, 32'h0);
    foreach (rows[i]) begin
      {lowSupplyIn, secondSupplySense, mainBelowBatteryIn} <= rows[i][6:4];
      repeat (12) @(posedge clk_sys);
      chk({27'h0, rstOeHi, lowOe, secOe, backupActive, rstOe},
          {27'h0, !rows[i][0], rows[i][3:0]});
    end
    waitOn(0, 1'b0, 2000);
    chkIn(n, 470, 530);
    for (int s = 0; s < 4; s++) begin
      ahb(1, OFS_CTRL, {28'h0, s[1:0], 2'h0});
      repeat (3) @(posedge clk_sys);
      chk({30'h0, nvStore}, {30'h0, s[1:0]});
      doKick(4'(3 * s));
      repeat (10) @(posedge clk_sys);
      chk1(wdOe, 1'b0);
      waitOn(1, 1'b1, s < 3 ? 15000 : 3000);
      if (s < 3) chkIn(n + 10, wdExp[s] - 20, wdExp[s] + 40);
      else chkIn(n, 3000, 3000);
    end
    chk1(irq, 1'b0);
    ahb(1, OFS_IRQ_MASK, 32'h1 << IRQ_WDOG);
    repeat (3) @(posedge clk_sys);
    chk1(irq, 1'b1);
    ahb(0, OFS_IRQ_STAT, 0);
    chk1(r[IRQ_WDOG], 1'b1);
    writeProtectIn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    ahb(1, OFS_IRQ_STAT, 32'h1 << IRQ_WDOG);
    ahb(1, OFS_CTRL, 32'h5);
    ahb(0, OFS_CTRL, 0);
    chk(r, 32'hc);
    chk1(irq, 1'b1);
    writeProtectIn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    ahb(1, OFS_IRQ_STAT, 32'h1 << IRQ_WDOG);
    repeat (3) @(posedge clk_sys);
    chk1(irq, 1'b0);
    ahb(0, 8'h40, 0);
    chk(r, 32'h0);
    for (int i = 0; i < 6; i++) begin
      manualResetIn <= i[0];
      repeat (5) @(posedge clk_sys);
    end
    repeat (60) @(posedge clk_sys);
    chk1(rstOe, 1'b0);
    for (int s = 0; s < 4; s++) begin
      ahb(1, OFS_CTRL, 32'hc | s);
      manualResetIn <= 1'b0;
      repeat (60) @(posedge clk_sys);
      chk1(rstOe, 1'b1);
      manualResetIn <= 1'b1;
      repeat (40) @(posedge clk_sys);
      chk({30'h0, rstOe, wdOe}, 32'h2);
      waitOn(0, 1'b0, 9000);
      chkIn(n + 40, holdExp[s], holdExp[s] + 60);
    end
    reset <= 1'b1;
    repeat (16) @(posedge clk_sys);
    chk1(rstOe, 1'b1);
    chk1(rstOeHi, 1'b0);
    reset <= 1'b0;
    ahb(0, OFS_CTRL, 0);
    chk(r, 32'hc);
    waitOn(0, 1'b0, 1000);
    chkIn(n, 470, 530);
    complete_run();
  end
endmodule // test_supply_supervisor_reset_watchdog
